/* File: hw/nsrm_pkg.sv */
// Shared constants for the network status and radio mode block
package nsrm_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] MS_CNT_MAX = 16'(MS_CYCLES - 1);

  localparam int unsigned HALF_5G_MS = 100;
  localparam int unsigned HALF_4G_MS = 200;
  localparam int unsigned HALF_3G_MS = 800;
  localparam logic [9:0] HALF_5G = 10'(HALF_5G_MS);
  localparam logic [9:0] HALF_4G = 10'(HALF_4G_MS);
  localparam logic [9:0] HALF_3G = 10'(HALF_3G_MS);

  // Module status codes presented by the modem core
  localparam logic [2:0] ST_OFF = 3'h0;
  localparam logic [2:0] ST_SLEEP = 3'h1;
  localparam logic [2:0] ST_SEARCH = 3'h2;
  localparam logic [2:0] ST_CALL = 3'h3;
  localparam logic [2:0] ST_5G = 3'h4;
  localparam logic [2:0] ST_4G = 3'h5;
  localparam logic [2:0] ST_3G = 3'h6;
  localparam logic [2:0] ST_IDLE = 3'h7;

  // Function level values of the function level command
  localparam logic [2:0] FUN_MIN = 3'h0;
  localparam logic [2:0] FUN_RF_ON = 3'h1;
  localparam logic [2:0] FUN_FLIGHT = 3'h4;
  localparam logic [2:0] FUN_RESET = FUN_RF_ON;

  localparam logic SYNC_SEL_RESET = 1'b0;
  localparam int unsigned GPIO_N = 38;

  typedef enum logic [2:0] {
    NSRM_MODE_RF_ON = 3'b001,
    NSRM_MODE_FLIGHT = 3'b010,
    NSRM_MODE_MIN = 3'b100
  } nsrm_mode_e;
endpackage : nsrm_pkg

/* File: hw/nsrm_blink.sv */
// Indicator cadence generator from a millisecond tick
`timescale 1ns/1ps
`default_nettype none
module nsrm_blink (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ms_tick, // One-cycle pulse per ms
  input wire logic restart, // Status changed
  input wire logic [9:0] half_ms, // On and off time in ms
  output logic phase_on // Blink phase
);
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic phase_nxt;
  wire half_done = (cnt_r == 10'(half_ms - 10'h001));

  assign cnt_nxt = restart ? 10'h000 : (ms_tick ? (half_done ? 10'h000 : 10'(cnt_r + 10'h001)) : cnt_r);
  assign phase_nxt = restart ? 1'b1 : ((ms_tick && half_done) ? ~phase_on : phase_on);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 10'h000;
      phase_on <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      phase_on <= phase_nxt;
    end
  end

  AST_RESTART_ON: assert property (@(posedge clk) disable iff (!rst_b)
    restart |=> phase_on && cnt_r == 10'h000) else $error("Cadence did not restart");
endmodule : nsrm_blink
`default_nettype wire

/* File: hw/nsrm_top.sv */
// Network indicator, radio mode and frame sync control
// How it works
// - Indicator is steadily on while searching or in a call.
// - 5G data or 5G registration blinks 100 ms on and 100 ms off.
// - 3G/4G data or 4G registration blinks 200 ms on and 200 ms off.
// - 3G registration blinks 800 ms on and 800 ms off.
// - Indicator is off when powered off or asleep.
// - The radio disable pin is active low.
// - A low radio disable pin forces flight mode over any software level.
// - With the pin high the commanded level applies, RF on by default.
// - Frame sync output pulses at each downlink-uplink frame start.
// - Software may route the satellite second pulse instead, never both.
// - General pins come up with pull-down enabled; one pin has no pull-up.
// - Only interrupt-capable pins raise interrupts, on level or edge.
`timescale 1ns/1ps
`default_nettype none
module nsrm_top (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [2:0] module_status, // Modem status code
  input wire logic radio_disable_b, // Radio disable pin, low = flight
  input wire logic [2:0] function_level_command, // Commanded function level
  input wire logic function_level_we, // Strobe for the level
  input wire logic frame_start, // Frame boundary pulse from modem
  input wire logic satnav_second_pulse, // Satellite 1PPS pin
  input wire logic sync_sel_pps, // 1 = route 1PPS to sync output
  input wire logic [nsrm_pkg::GPIO_N-1:0] gpio_in, // General pin levels
  input wire logic [nsrm_pkg::GPIO_N-1:0] gpio_irq_cap, // Pin may interrupt
  input wire logic [nsrm_pkg::GPIO_N-1:0] gpio_irq_en, // Interrupt enable
  input wire logic [nsrm_pkg::GPIO_N-1:0] gpio_irq_edge, // 1 = edge, 0 = level
  input wire logic [nsrm_pkg::GPIO_N-1:0] gpio_pu_req, // Pull-up request
  output logic network_indicator_out, // LED drive
  output logic rf_enable, // RF section enabled
  output logic card_enable, // Card function on
  output logic [2:0] radio_mode, // One-hot radio mode
  output logic frame_sync_pulse_out, // Frame sync or 1PPS
  output logic [nsrm_pkg::GPIO_N-1:0] pulled_down_default, // Pull-down enable
  output logic [nsrm_pkg::GPIO_N-1:0] pullup_en, // Pull-up enable
  output logic gpio_irq // Pin interrupt
);
  // Index of the pin that must never be pulled up
  localparam int unsigned NO_PULLUP_IDX = 15;

  // Pin synchronisers
  logic dis_s1_r, dis_s2_r, pps_s1_r, pps_s2_r, pps_d_r;
  logic [nsrm_pkg::GPIO_N-1:0] gp_s1_r, gp_s2_r, gp_d_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dis_s1_r <= 1'b1;
      dis_s2_r <= 1'b1;
      pps_s1_r <= 1'b0;
      pps_s2_r <= 1'b0;
      pps_d_r <= 1'b0;
      gp_s1_r <= '0;
      gp_s2_r <= '0;
      gp_d_r <= '0;
    end else begin
      dis_s1_r <= radio_disable_b;
      dis_s2_r <= dis_s1_r;
      pps_s1_r <= satnav_second_pulse;
      pps_s2_r <= pps_s1_r;
      pps_d_r <= pps_s2_r;
      gp_s1_r <= gpio_in;
      gp_s2_r <= gp_s1_r;
      gp_d_r <= gp_s2_r;
    end
  end

  // Millisecond time base
  logic [15:0] ms_cnt_r;
  logic ms_tick_r;
  wire ms_wrap = (ms_cnt_r == nsrm_pkg::MS_CNT_MAX);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b0;
    end else begin
      ms_cnt_r <= ms_wrap ? 16'h0000 : 16'(ms_cnt_r + 16'h0001);
      ms_tick_r <= ms_wrap;
    end
  end

  // Status decode
  logic [2:0] status_r;
  wire status_chg = (module_status != status_r);
  wire st_steady = (status_r == nsrm_pkg::ST_SEARCH) || (status_r == nsrm_pkg::ST_CALL);
  wire st_blink5 = (status_r == nsrm_pkg::ST_5G);
  wire st_blink4 = (status_r == nsrm_pkg::ST_4G);
  wire st_blink3 = (status_r == nsrm_pkg::ST_3G);
  wire st_blink = st_blink5 | st_blink4 | st_blink3;
  wire [9:0] half_sel = st_blink5 ? nsrm_pkg::HALF_5G : (st_blink4 ? nsrm_pkg::HALF_4G : nsrm_pkg::HALF_3G);
  wire phase_on;
  // Off, sleep and idle all leave the LED dark
  wire led_nxt = st_steady | (st_blink & phase_on);

  nsrm_blink u_blink (
    .clk(clk),
    .rst_b(rst_b),
    .ms_tick(ms_tick_r),
    .restart(status_chg),
    .half_ms(half_sel),
    .phase_on(phase_on)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= nsrm_pkg::ST_OFF;
      network_indicator_out <= 1'b0;
    end else begin
      status_r <= module_status;
      network_indicator_out <= led_nxt;
    end
  end

  // Radio mode: pin beats command
  logic [2:0] level_r;
  wire [2:0] lvl_nxt = function_level_we ? function_level_command : level_r;
  wire pin_flight = ~dis_s2_r;
  nsrm_pkg::nsrm_mode_e mode_nxt;
  always_comb begin
    if (pin_flight) begin
      mode_nxt = nsrm_pkg::NSRM_MODE_FLIGHT;
    end else begin
      case (level_r)
        nsrm_pkg::FUN_MIN: mode_nxt = nsrm_pkg::NSRM_MODE_MIN;
        nsrm_pkg::FUN_FLIGHT: mode_nxt = nsrm_pkg::NSRM_MODE_FLIGHT;
        nsrm_pkg::FUN_RF_ON: mode_nxt = nsrm_pkg::NSRM_MODE_RF_ON;
        default: mode_nxt = nsrm_pkg::NSRM_MODE_RF_ON;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_r <= nsrm_pkg::FUN_RESET;
      radio_mode <= nsrm_pkg::NSRM_MODE_RF_ON;
      rf_enable <= 1'b1;
      card_enable <= 1'b1;
    end else begin
      level_r <= lvl_nxt;
      radio_mode <= mode_nxt;
      rf_enable <= (mode_nxt == nsrm_pkg::NSRM_MODE_RF_ON);
      // Pin-forced flight keeps the card function alive
      card_enable <= (mode_nxt != nsrm_pkg::NSRM_MODE_MIN);
    end
  end

  // Frame sync output: one source at a time
  logic sel_r;
  wire pps_rise = pps_s2_r & ~pps_d_r;
  wire sync_nxt = sel_r ? pps_rise : frame_start;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= nsrm_pkg::SYNC_SEL_RESET;
      frame_sync_pulse_out <= 1'b0;
    end else begin
      sel_r <= sync_sel_pps;
      frame_sync_pulse_out <= sync_nxt;
    end
  end

  // Pad pulls and pin interrupts
  wire [nsrm_pkg::GPIO_N-1:0] pu_mask = ~(nsrm_pkg::GPIO_N'(1) << NO_PULLUP_IDX);
  wire [nsrm_pkg::GPIO_N-1:0] pu_nxt = gpio_pu_req & pu_mask;
  wire [nsrm_pkg::GPIO_N-1:0] lvl_hit = gp_s2_r;
  wire [nsrm_pkg::GPIO_N-1:0] edge_hit = gp_s2_r & ~gp_d_r;
  wire [nsrm_pkg::GPIO_N-1:0] src_hit = (gpio_irq_edge & edge_hit) | (~gpio_irq_edge & lvl_hit);
  wire irq_nxt = |(src_hit & gpio_irq_en & gpio_irq_cap);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulled_down_default <= {nsrm_pkg::GPIO_N{1'b1}};
      pullup_en <= '0;
      gpio_irq <= 1'b0;
    end else begin
      pulled_down_default <= ~pu_nxt;
      pullup_en <= pu_nxt;
      gpio_irq <= irq_nxt;
    end
  end

  AST_STEADY_ON: assert property (@(posedge clk) disable iff (!rst_b)
    st_steady |=> network_indicator_out) else $error("Indicator not steady on");
  AST_BLINK_5G: assert property (@(posedge clk) disable iff (!rst_b)
    st_blink5 && !status_chg |-> half_sel == 10'd100) else $error("Wrong 5G half period");
  AST_BLINK_4G: assert property (@(posedge clk) disable iff (!rst_b)
    st_blink4 |-> half_sel == 10'd200) else $error("Wrong 4G half period");
  AST_BLINK_3G: assert property (@(posedge clk) disable iff (!rst_b)
    st_blink3 |-> half_sel == 10'd800) else $error("Wrong 3G half period");
  AST_DARK: assert property (@(posedge clk) disable iff (!rst_b)
    (status_r == nsrm_pkg::ST_SLEEP || status_r == nsrm_pkg::ST_OFF) |=> !network_indicator_out)
    else $error("Indicator lit while off or asleep");
  AST_PIN_FLIGHT: assert property (@(posedge clk) disable iff (!rst_b)
    !radio_disable_b [*3] |=> !rf_enable && radio_mode == nsrm_pkg::NSRM_MODE_FLIGHT)
    else $error("Pin did not force flight");
  AST_CMD_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
    dis_s2_r && level_r == nsrm_pkg::FUN_MIN |=> !card_enable && !rf_enable)
    else $error("Minimal level not applied");
  AST_SYNC_FRAME: assert property (@(posedge clk) disable iff (!rst_b)
    !sel_r && frame_start |=> frame_sync_pulse_out) else $error("Frame pulse lost");
  AST_SYNC_EXCL: assert property (@(posedge clk) disable iff (!rst_b)
    sel_r && !pps_rise |=> !frame_sync_pulse_out) else $error("Frame pulse leaked in 1PPS mode");
  AST_NO_PULLUP: assert property (@(posedge clk) disable iff (!rst_b)
    !pullup_en[NO_PULLUP_IDX]) else $error("Forbidden pin pulled up");
  AST_IRQ_CAP: assert property (@(posedge clk) disable iff (!rst_b)
    !(|(gpio_irq_cap & gpio_irq_en)) |=> !gpio_irq) else $error("Interrupt from incapable pin");
endmodule : nsrm_top
`default_nettype wire

/* File: sim/nsrm_board_model.sv */
// Board side model: host disable line, satellite pulse source, sync input
`timescale 1ns/1ps
`default_nettype none
module nsrm_board_model (
  input wire logic clk, // Board clock
  input wire logic wdis_req, // Host asks for flight
  input wire logic pps_req, // Rise starts one satellite pulse
  input wire logic frame_sync_pulse_out, // Sync line seen
  output wire logic radio_disable_b, // Host line, active low
  output logic satnav_second_pulse, // Satellite pulse pin
  output int sync_seen // Sync high cycles counted
);
  assign radio_disable_b = ~wdis_req;
  initial begin
    sync_seen = 0;
    satnav_second_pulse = 1'b0;
  end
  // Long pulse, so only its rising edge can matter
  always @(posedge pps_req) begin
    satnav_second_pulse <= 1'b1;
    repeat (10) @(posedge clk);
    #3 satnav_second_pulse <= 1'b0;
  end
  always @(posedge clk) begin
    if (frame_sync_pulse_out === 1'b1) sync_seen <= sync_seen + 1;
  end
endmodule : nsrm_board_model
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the status and radio mode block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int N = nsrm_pkg::GPIO_N;
  logic clk, rst_b, fwe, fstart, sel, wdis, pps, led, rf, card, fsync, rdb, sat, irq;
  logic [2:0] stat, lvl, mode;
  logic [N-1:0] gin, cap, en, edg, pu, pd, pue;
  int err_count, num_checks, seed, n0;
  nsrm_top dut (.clk(clk), .rst_b(rst_b), .module_status(stat), .radio_disable_b(rdb),
    .function_level_command(lvl), .function_level_we(fwe), .frame_start(fstart),
    .satnav_second_pulse(sat), .sync_sel_pps(sel), .gpio_in(gin), .gpio_irq_cap(cap),
    .gpio_irq_en(en), .gpio_irq_edge(edg), .gpio_pu_req(pu), .network_indicator_out(led),
    .rf_enable(rf), .card_enable(card), .radio_mode(mode), .frame_sync_pulse_out(fsync),
    .pulled_down_default(pd), .pullup_en(pue), .gpio_irq(irq));
  nsrm_board_model board (.clk(clk), .wdis_req(wdis), .pps_req(pps), .frame_sync_pulse_out(fsync),
    .radio_disable_b(rdb), .satnav_second_pulse(sat), .sync_seen(n0));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task chk(input logic [N-1:0] got, input logic [N-1:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task end_sim;
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Blink states restart in the on phase and the whole run is far below 99 ms
  function automatic logic exp_led(input logic [2:0] s);
    return (s == nsrm_pkg::ST_SEARCH || s == nsrm_pkg::ST_CALL || s == nsrm_pkg::ST_5G ||
      s == nsrm_pkg::ST_4G || s == nsrm_pkg::ST_3G);
  endfunction : exp_led
  function automatic logic [4:0] exp_mode(input logic [2:0] l, input logic pin_low);
    if (pin_low) return {3'h2, 2'b01};
    if (l == nsrm_pkg::FUN_MIN) return {3'h4, 2'b00};
    if (l == nsrm_pkg::FUN_FLIGHT) return {3'h2, 2'b01};
    return {3'h1, 2'b11};
  endfunction : exp_mode
  initial begin
    #500000;
    err_count++;
    end_sim();
  end
  initial begin
    int s, w;
    logic [N-1:0] e;
    seed = 17;
    {rst_b, fwe, fstart, sel, wdis, pps, stat, lvl} = '0;
    {gin, cap, en, edg, pu} = '0;
    repeat (2) @(posedge clk);
    #2 rst_b = 1'b1;
    chk({led, rf, card, mode, fsync, irq}, 8'h64, "reset outputs");
    chk(pd, {N{1'b1}}, "reset pull-down");
    chk(pue, '0, "reset pull-up");
    for (int i = 0; i < 27; i++) begin
      s = (i < 8) ? i : $unsigned($random(seed)) % 8;
      stat = 3'(s);
      tick(4);
      chk(led, exp_led(stat), "indicator");
      tick(40);
      chk(led, exp_led(stat), "indicator held");
    end
    // Back to back strobes: the second level must win
    for (int i = 0; i < 24; i++) begin
      w = (i < 16) ? i : $random(seed);
      lvl = 3'($random(seed));
      fwe = 1'b1;
      tick(1);
      lvl = 3'(w);
      tick(1);
      fwe = 1'b0;
      wdis = w[3];
      tick(6);
      chk({mode, rf, card}, exp_mode(3'(w), w[3]), "radio mode");
    end
    for (int i = 0; i < 6; i++) begin
      sel = i[0];
      tick(3);
      s = n0;
      fstart = (i[1] | i[2]);
      pps = (!i[1] | i[2]);
      tick(1);
      fstart = 1'b0;
      tick(15);
      pps = 1'b0;
      chk(N'(n0 - s), N'(i[0] ? (!i[1] | i[2]) : (i[1] | i[2])), "sync pulses");
    end
    for (int i = 0; i < 12; i++) begin
      pu = (i == 0) ? {N{1'b1}} : N'({$random(seed), $random(seed)});
      gin = N'({$random(seed), $random(seed)});
      cap = N'({$random(seed), $random(seed)});
      en = (i == 1) ? ~cap : N'({$random(seed), $random(seed)});
      edg = (i < 2) ? {N{1'b0}} : N'({$random(seed), $random(seed)});
      tick(6);
      e = pu & ~(N'(1) << 15);
      chk(pue, e, "pull-up");
      chk(pd, ~e, "pull-down");
      chk(N'(irq), N'(|(gin & cap & en & ~edg)), "pin interrupt");
    end
    end_sim();
  end
endmodule : testbench
`default_nettype wire
